/* File: shared/cbw_pkg.sv */
// Purpose: shared constants and carriers for the bridge I/O window control slice
// Assumes: configuration accesses arrive as dword-aligned byte addresses with byte enables
// Notes:   one state struct holds every flip-flop of the main module

package cbw_pkg;

  // ---------------------------------------------------------------------------
  // configuration offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  CBW_OFS_IO_WIN0_UB   = 8'h30;
  localparam logic [7:0]  CBW_OFS_IO_WIN1_UB   = 8'h38;
  localparam logic [7:0]  CBW_OFS_IRQ_LINE     = 8'h3c;
  localparam logic [7:0]  CBW_OFS_IRQ_PIN      = 8'h3d;
  localparam logic [7:0]  CBW_OFS_BRIDGING_CTL = 8'h3e;

  // ---------------------------------------------------------------------------
  // reset values and write masks
  // ---------------------------------------------------------------------------
  localparam logic [31:0] CBW_IO_UB_RESET   = 32'h0000_0000;
  localparam logic [31:0] CBW_IO_UB_WMASK   = 32'h0000_fffc;
  localparam logic [7:0]  CBW_LINE_RESET    = 8'hff;
  localparam logic [7:0]  CBW_PIN_RESET     = 8'h01;
  localparam logic [15:0] CBW_BRCTL_RESET   = 16'h0340;
  localparam logic [15:0] CBW_BRCTL_WMASK   = 16'h07ef;
  localparam int          CBW_WIN_COUNT     = 2;

  // ---------------------------------------------------------------------------
  // bridging control field positions
  // ---------------------------------------------------------------------------
  localparam int CBW_BC_POST  = 10;
  localparam int CBW_BC_PF1   = 9;
  localparam int CBW_BC_PF0   = 8;
  localparam int CBW_BC_ROUTE = 7;
  localparam int CBW_BC_SRST  = 6;
  localparam int CBW_BC_MABT  = 5;
  localparam int CBW_BC_VGA   = 3;
  localparam int CBW_BC_ISA   = 2;
  localparam int CBW_BC_SERR  = 1;
  localparam int CBW_BC_PERR  = 0;

  // ---------------------------------------------------------------------------
  // interrupt signaling modes and address ranges
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  CBW_INTERRUPT_SIGNALING_MODE_PAR_PCI   = 2'b00;
  localparam logic [1:0]  CBW_INTERRUPT_SIGNALING_MODE_ISA_ONLY  = 2'b01;
  localparam logic [1:0]  CBW_INTERRUPT_SIGNALING_MODE_SER_ISA   = 2'b10;
  localparam logic [1:0]  CBW_INTERRUPT_SIGNALING_MODE_SER_PCI   = 2'b11;
  localparam logic [31:0] CBW_VGA_MEM_LO  = 32'h000a_0000;
  localparam logic [31:0] CBW_VGA_MEM_HI  = 32'h000b_ffff;
  localparam logic [31:0] CBW_VGA_IO0_LO  = 32'h0000_03b0;
  localparam logic [31:0] CBW_VGA_IO0_HI  = 32'h0000_03bb;
  localparam logic [31:0] CBW_VGA_IO1_LO  = 32'h0000_03c0;
  localparam logic [31:0] CBW_VGA_IO1_HI  = 32'h0000_03df;
  localparam logic [15:0] CBW_ISA_PAGE    = 16'h0000;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cbw_cfg_req_s;

  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic [31:0] addr;
  } cbw_fwd_req_s;

  typedef struct packed {
    logic write_posting_enable;
    logic window1_prefetchable;
    logic window0_prefetchable;
    logic functional_irq_route_select;
    logic vga_forward_enable;
    logic isa_alias_filter_enable;
  } cbw_ctrl_s;

  typedef struct packed {
    logic [CBW_WIN_COUNT-1:0][13:0] lim;
    logic [7:0]                     line;
    logic [15:0]                    brctl;
    logic [31:0]                    rdata;
    logic                           rvalid;
    logic [1:0]                     serr_sync;
    logic                           card_reset;
    logic                           pci_claim;
    logic                           card_to_host;
    logic                           target_abort;
    logic                           pci_serr;
    logic                           card_perr;
  } cbw_state_s;

  localparam cbw_state_s CBW_STATE_RESET = '{
    lim:          {CBW_IO_UB_RESET[15:2], CBW_IO_UB_RESET[15:2]},
    line:         CBW_LINE_RESET,
    brctl:        CBW_BRCTL_RESET,
    rdata:        32'h0000_0000,
    rvalid:       1'b0,
    serr_sync:    2'b00,
    card_reset:   1'b1,
    pci_claim:    1'b0,
    card_to_host: 1'b0,
    target_abort: 1'b0,
    pci_serr:     1'b0,
    card_perr:    1'b0
  };

endpackage

/* File: verilog/cbw_io_window_match.sv */
// Purpose: decides whether one I/O address falls inside one I/O window
// Assumes: base bits 1..0 already read as zero
// Notes:   purely combinational
`timescale 1ns/100ps

module cbw_io_window_match (
  input  wire logic [31:0] i_base,
  input  wire logic [13:0] i_limit,
  input  wire logic [31:0] i_addr,
  output logic             o_hit
);

  logic        win_en;
  logic [31:0] upper;

  always_comb begin
    // window live only if base or limit nonzero
    win_en = (i_base != 32'h0000_0000) || (i_limit != 14'h0000);
    // page from base, low two limit bits taken as ones
    upper  = {i_base[31:16], i_limit, 2'b11};
    o_hit  = win_en && (i_addr >= i_base) && (i_addr <= upper);
  end

endmodule

/* File: verilog/cbw_bridge_ctrl.sv */
// Purpose: I/O window upper bounds, interrupt line/pin and bridging control
// Assumes: i_srst is the host bus reset; config port is single-cycle
// Notes:   read data appears one cycle after the read strobe
`timescale 1ns/100ps

module cbw_bridge_ctrl
  import cbw_pkg::*;
#(
  parameter int WIN_COUNT = CBW_WIN_COUNT
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_srst,
  input  wire cbw_cfg_req_s                i_cfg,
  output logic [31:0]                      o_cfg_rdata,
  output logic                             o_cfg_rvalid,
  input  wire logic [WIN_COUNT-1:0][31:0]  i_io_base,
  input  wire logic [1:0]                  i_interrupt_signaling_mode,
  input  wire logic [2:0]                  i_function_num,
  input  wire cbw_fwd_req_s                i_pci_req,
  output logic                             o_pci_claim,
  input  wire cbw_fwd_req_s                i_card_req,
  output logic                             o_card_to_host,
  input  wire logic                        i_card_master_abort,
  input  wire logic                        i_serr_enable,
  output logic                             o_pci_target_abort,
  output logic                             o_pci_serr,
  input  wire logic                        i_card_serr_n,
  input  wire logic                        i_card_parity_err,
  output logic                             o_card_perr,
  output logic                             o_card_reset,
  output cbw_ctrl_s                        o_ctrl
);

  // ---------------------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------------------
  if (WIN_COUNT != CBW_WIN_COUNT) begin : g_bad_win
    $error("window count must match the state layout");
  end

  // ---------------------------------------------------------------------------
  // state and helpers
  // ---------------------------------------------------------------------------
  cbw_state_s             s_r;
  cbw_state_s             s_nxt;
  logic [WIN_COUNT-1:0]   pci_hit;
  logic [WIN_COUNT-1:0]   card_hit;

  function automatic logic [31:0] cbw_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be, input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old_v & ~m) | (new_v & m);
  endfunction

  function automatic logic [7:0] cbw_pin_value(input logic [1:0] mode, input logic [2:0] fn);
    logic [7:0] v;
    v = 8'h00;
    if (mode != CBW_INTERRUPT_SIGNALING_MODE_ISA_ONLY) begin
      v = 8'(CBW_PIN_RESET + {5'b00000, fn});
    end
    return v;
  endfunction

  // ---------------------------------------------------------------------------
  // window matchers
  // ---------------------------------------------------------------------------
  for (genvar w = 0; w < WIN_COUNT; w++) begin : g_win
    cbw_io_window_match u_pci_match (
      .i_base  (i_io_base[w]),
      .i_limit (s_r.lim[w]),
      .i_addr  (i_pci_req.addr),
      .o_hit   (pci_hit[w])
    );
    cbw_io_window_match u_card_match (
      .i_base  (i_io_base[w]),
      .i_limit (s_r.lim[w]),
      .i_addr  (i_card_req.addr),
      .o_hit   (card_hit[w])
    );
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  logic [31:0] lim_word;
  logic [31:0] ctl_word;
  logic [7:0]  pin_val;
  logic        isa_block;
  logic        vga_io;
  logic        vga_mem;

  always_comb begin
    s_nxt     = s_r;
    lim_word  = 32'h0000_0000;
    ctl_word  = 32'h0000_0000;
    pin_val   = cbw_pin_value(i_interrupt_signaling_mode, i_function_num);
    isa_block = 1'b0;
    vga_io    = 1'b0;
    vga_mem   = 1'b0;

    // config writes
    if (i_cfg.wr) begin
      for (int w = 0; w < WIN_COUNT; w++) begin
        if (i_cfg.addr[7:2] == (w == 0 ? CBW_OFS_IO_WIN0_UB[7:2] : CBW_OFS_IO_WIN1_UB[7:2])) begin
          // only bits 15..2 take write data
          lim_word = cbw_merge({16'h0000, s_r.lim[w], 2'b00}, i_cfg.wdata, i_cfg.be,
                               CBW_IO_UB_WMASK);
          s_nxt.lim[w] = lim_word[15:2];
        end
      end
      if (i_cfg.addr[7:2] == CBW_OFS_IRQ_LINE[7:2]) begin
        // pin byte is read-only; reserved control bits masked off
        ctl_word = cbw_merge({s_r.brctl, 8'h00, s_r.line}, i_cfg.wdata, i_cfg.be,
                             {CBW_BRCTL_WMASK, 8'h00, 8'hff});
        s_nxt.line  = ctl_word[7:0];
        s_nxt.brctl = ctl_word[31:16];
      end
    end

    // config reads
    s_nxt.rvalid = i_cfg.rd;
    if (i_cfg.rd) begin
      s_nxt.rdata = 32'h0000_0000;
      if (i_cfg.addr[7:2] == CBW_OFS_IO_WIN0_UB[7:2]) begin
        s_nxt.rdata = {16'h0000, s_r.lim[0], 2'b00};
      end else if (i_cfg.addr[7:2] == CBW_OFS_IO_WIN1_UB[7:2]) begin
        s_nxt.rdata = {16'h0000, s_r.lim[1], 2'b00};
      end else if (i_cfg.addr[7:2] == CBW_OFS_IRQ_LINE[7:2]) begin
        s_nxt.rdata = {s_r.brctl & CBW_BRCTL_WMASK, pin_val, s_r.line};
      end
    end

    // forwarding decisions
    isa_block = s_r.brctl[CBW_BC_ISA] && (i_pci_req.addr[31:16] == CBW_ISA_PAGE) &&
                (i_pci_req.addr[9:8] != 2'b00);
    vga_io    = ((i_pci_req.addr >= CBW_VGA_IO0_LO) && (i_pci_req.addr <= CBW_VGA_IO0_HI)) ||
                ((i_pci_req.addr >= CBW_VGA_IO1_LO) && (i_pci_req.addr <= CBW_VGA_IO1_HI));
    vga_mem   = (i_pci_req.addr >= CBW_VGA_MEM_LO) && (i_pci_req.addr <= CBW_VGA_MEM_HI);
    s_nxt.pci_claim = i_pci_req.valid &&
                      ((i_pci_req.is_io && (|pci_hit) && !isa_block) ||
                       (s_r.brctl[CBW_BC_VGA] && (i_pci_req.is_io ? vga_io : vga_mem)));
    s_nxt.card_to_host = i_card_req.valid && i_card_req.is_io && !(|card_hit);

    // error reporting
    s_nxt.serr_sync[0] = ~i_card_serr_n;
    s_nxt.serr_sync[1] = s_r.serr_sync[0];
    s_nxt.target_abort = i_card_master_abort && s_r.brctl[CBW_BC_MABT];
    s_nxt.pci_serr     = (s_nxt.target_abort && i_serr_enable) ||
                         (s_r.serr_sync[1] && s_r.brctl[CBW_BC_SERR]);
    s_nxt.card_perr    = i_card_parity_err && s_r.brctl[CBW_BC_PERR];

    // socket reset follows the control bit after each write
    s_nxt.card_reset   = s_nxt.brctl[CBW_BC_SRST];
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_r <= CBW_STATE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign o_cfg_rdata        = s_r.rdata;
  assign o_cfg_rvalid       = s_r.rvalid;
  assign o_pci_claim        = s_r.pci_claim;
  assign o_card_to_host     = s_r.card_to_host;
  assign o_pci_target_abort = s_r.target_abort;
  assign o_pci_serr         = s_r.pci_serr;
  assign o_card_perr        = s_r.card_perr;
  assign o_card_reset       = s_r.card_reset;
  assign o_ctrl = '{
    write_posting_enable:        s_r.brctl[CBW_BC_POST],
    window1_prefetchable:        s_r.brctl[CBW_BC_PF1],
    window0_prefetchable:        s_r.brctl[CBW_BC_PF0],
    functional_irq_route_select: s_r.brctl[CBW_BC_ROUTE],
    vga_forward_enable:          s_r.brctl[CBW_BC_VGA],
    isa_alias_filter_enable:     s_r.brctl[CBW_BC_ISA]
  };

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  limit_read_zero_a: assert property (
    (i_cfg.rd && (i_cfg.addr[7:2] == CBW_OFS_IO_WIN0_UB[7:2])) |=>
      (o_cfg_rvalid && (o_cfg_rdata[31:16] == 16'h0000) && (o_cfg_rdata[1:0] == 2'b00)))
    else $error("limit read shows nonzero read-only bits");

  limit_write_a: assert property (
    (i_cfg.wr && (i_cfg.addr[7:2] == CBW_OFS_IO_WIN1_UB[7:2]) && (i_cfg.be == 4'hf)) |=>
      (s_r.lim[1] == $past(i_cfg.wdata[15:2])))
    else $error("limit write did not land in bits 15..2");

  ctl_reserved_a: assert property (
    (i_cfg.rd && (i_cfg.addr[7:2] == CBW_OFS_IRQ_LINE[7:2])) |=>
      ((o_cfg_rdata[31:27] == 5'b00000) && !o_cfg_rdata[20]))
    else $error("reserved control bits read nonzero");

  sock_reset_off_a: assert property (
    (i_cfg.wr && (i_cfg.addr[7:2] == CBW_OFS_IRQ_LINE[7:2]) && i_cfg.be[2] &&
     !i_cfg.wdata[16 + CBW_BC_SRST]) |=> !o_card_reset)
    else $error("card reset stayed after clearing its bit");

  host_reset_a: assert property (
    disable iff (1'b0) $past(i_srst) |-> o_card_reset)
    else $error("card reset missing after host reset");

  abort_mode_a: assert property (
    i_card_master_abort |=> (o_pci_target_abort == $past(s_r.brctl[CBW_BC_MABT])))
    else $error("master abort report does not follow mode");

  serr_gate_a: assert property (
    ($past(!s_r.brctl[CBW_BC_SERR]) && $past(!s_r.brctl[CBW_BC_MABT])) |-> !o_pci_serr)
    else $error("system error forwarded while disabled");

  parity_gate_a: assert property (
    i_card_parity_err |=> (o_card_perr == $past(s_r.brctl[CBW_BC_PERR])))
    else $error("parity report does not follow enable");

  window_off_a: assert property (
    (i_pci_req.valid && i_pci_req.is_io && !s_r.brctl[CBW_BC_VGA] &&
     (i_io_base == '0) && (s_r.lim == '0)) |=> !o_pci_claim)
    else $error("claimed through an unprogrammed window");

  isa_filter_a: assert property (
    (i_pci_req.valid && i_pci_req.is_io && s_r.brctl[CBW_BC_ISA] &&
     !(s_r.brctl[CBW_BC_VGA] && (i_pci_req.addr[15:8] == 8'h03)) &&
     (i_pci_req.addr[31:16] == 16'h0000) && (i_pci_req.addr[9:8] != 2'b00)) |=> !o_pci_claim)
    else $error("ISA alias forwarded to card");

  vga_claim_a: assert property (
    (i_pci_req.valid && !i_pci_req.is_io && s_r.brctl[CBW_BC_VGA] &&
     (i_pci_req.addr >= CBW_VGA_MEM_LO) && (i_pci_req.addr <= CBW_VGA_MEM_HI)) |=> o_pci_claim)
    else $error("VGA memory access not forwarded");

  card_forward_a: assert property (
    (i_card_req.valid && i_card_req.is_io && (i_io_base == '0) && (s_r.lim == '0)) |=>
      o_card_to_host)
    else $error("card I/O outside windows not sent to host");

  pci_idle_a: assert property (
    !i_pci_req.valid |=> !o_pci_claim)
    else $error("claim without a host request");

  sock_reset_on_a: assert property (
    (i_cfg.wr && (i_cfg.addr[7:2] == CBW_OFS_IRQ_LINE[7:2]) && i_cfg.be[2] &&
     i_cfg.wdata[16 + CBW_BC_SRST]) |=> o_card_reset)
    else $error("card reset not raised by its bit");

  pin_read_a: assert property (
    (i_cfg.rd && (i_cfg.addr[7:2] == CBW_OFS_IRQ_LINE[7:2]) &&
     (i_interrupt_signaling_mode == CBW_INTERRUPT_SIGNALING_MODE_ISA_ONLY)) |=> (o_cfg_rdata[15:8] == 8'h00))
    else $error("pin byte nonzero in ISA-only mode");

  limit_inclusive_a: assert property (
    (i_pci_req.valid && i_pci_req.is_io && !s_r.brctl[CBW_BC_ISA] && (i_io_base[0] != 32'h0000_0000) &&
     (i_pci_req.addr[31:16] == i_io_base[0][31:16]) && (i_pci_req.addr[15:2] == s_r.lim[0]) &&
     (i_pci_req.addr >= i_io_base[0])) |=> o_pci_claim)
    else $error("top doubleword of window not claimed");

  serr_forward_a: assert property (
    (s_r.serr_sync[1] && s_r.brctl[CBW_BC_SERR]) |=> o_pci_serr)
    else $error("enabled card system error not forwarded");

  ctl_write_a: assert property (
    (i_cfg.wr && (i_cfg.addr[7:2] == CBW_OFS_IRQ_LINE[7:2]) && (i_cfg.be == 4'hf)) |=>
      (s_r.brctl == ($past(i_cfg.wdata[31:16]) & CBW_BRCTL_WMASK)))
    else $error("control write did not honour reserved bits");

  claim_cov: cover property (i_pci_req.valid ##1 o_pci_claim);
  isa_cov: cover property (o_ctrl.isa_alias_filter_enable && i_pci_req.valid);
  abort_cov: cover property (o_pci_target_abort && o_pci_serr);
  reset_release_cov: cover property (o_card_reset ##1 !o_card_reset);
  perr_cov: cover property (o_card_perr);

endmodule

/* File: sim/cbw_card_model.sv */
// Purpose: behavioural card standing in the socket at the far side
// Assumes: error pin is open-drain with a pull-up, so released reads high
// Notes:   a card held in socket reset drives nothing
`timescale 1ns/100ps

module cbw_card_model (
  input  wire logic i_clk,
  input  wire logic i_card_reset,
  input  wire logic i_serr_cmd,
  input  wire logic i_perr_cmd,
  input  wire logic i_abort_cmd,
  output logic      o_card_serr_n,
  output logic      o_card_parity_err,
  output logic      o_card_master_abort
);
  // ---------------------------------------------------------------------------
  // pins, launched just after the edge
  // ---------------------------------------------------------------------------
  initial begin
    o_card_serr_n       = 1'b1;
    o_card_parity_err   = 1'b0;
    o_card_master_abort = 1'b0;
  end

  always @(posedge i_clk) begin
    o_card_serr_n       <= ~(i_serr_cmd & ~i_card_reset);
    o_card_parity_err   <= i_perr_cmd & ~i_card_reset;
    o_card_master_abort <= i_abort_cmd & ~i_card_reset;
  end
endmodule

/* File: sim/cbw_bridge_ctrl_tb.sv */
// Purpose: self-checking bench for the bridge control slice
// Assumes: base registers and mode field are driven from here
// Notes:   register table first, then hand-written cases
`timescale 1ns/100ps

module cbw_bridge_ctrl_tb;
  import cbw_pkg::*;

  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
    logic [31:0] exp;
  } cbw_row_s;

  logic             clk;
  logic             srst;
  cbw_cfg_req_s     cfg;
  logic [1:0][31:0] base;
  logic [1:0]       mode;
  logic [2:0]       fn;
  cbw_fwd_req_s     preq;
  cbw_fwd_req_s     creq;
  logic             serr_en, serr_c, perr_c, abt_c;
  logic [31:0]      rdata;
  logic             rvalid, claim, c2h, tabt, pserr, perr, socket_reset_control, serr_n, par_err, mabt;
  cbw_ctrl_s        ctrl;
  int               fails;
  int               compares;
  cbw_row_s         rows [11];

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  cbw_bridge_ctrl dut (
    .i_clk(clk), .i_srst(srst), .i_cfg(cfg), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
    .i_io_base(base), .i_interrupt_signaling_mode(mode), .i_function_num(fn),
    .i_pci_req(preq), .o_pci_claim(claim), .i_card_req(creq), .o_card_to_host(c2h),
    .i_card_master_abort(mabt), .i_serr_enable(serr_en), .o_pci_target_abort(tabt),
    .o_pci_serr(pserr), .i_card_serr_n(serr_n), .i_card_parity_err(par_err),
    .o_card_perr(perr), .o_card_reset(socket_reset_control), .o_ctrl(ctrl)
  );

  cbw_card_model card (
    .i_clk(clk), .i_card_reset(socket_reset_control), .i_serr_cmd(serr_c), .i_perr_cmd(perr_c),
    .i_abort_cmd(abt_c), .o_card_serr_n(serr_n), .o_card_parity_err(par_err),
    .o_card_master_abort(mabt)
  );

  // ---------------------------------------------------------------------------
  // compares and bus tasks
  // ---------------------------------------------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    cfg <= '{1'b1, 1'b0, a, be, d};
    @(posedge clk);
    cfg <= '0;
  endtask

  task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    cfg <= '{1'b0, 1'b1, a, 4'hf, 32'h0000_0000};
    @(posedge clk);
    cfg <= '0;
    #1;
    chk_bit(rvalid, 1'b1);
    chk_word(rdata, exp);
  endtask

  task automatic pci(input logic [31:0] a, input logic io, input logic exp);
    @(posedge clk);
    preq <= '{1'b1, io, a};
    @(posedge clk);
    preq <= '0;
    #1;
    chk_bit(claim, exp);
  endtask

  task automatic card_io(input logic [31:0] a, input logic exp);
    @(posedge clk);
    creq <= '{1'b1, 1'b1, a};
    @(posedge clk);
    creq <= '0;
    #1;
    chk_bit(c2h, exp);
  endtask

  // card event: model launches a cycle later, dut answers one after that
  task automatic card_ev(input logic ab, input logic pe, input logic [2:0] exp);
    @(posedge clk);
    {abt_c, perr_c} <= {ab, pe};
    @(posedge clk);
    {abt_c, perr_c} <= 2'b00;
    @(posedge clk);
    #1;
    chk_word({29'h0, tabt, pserr, perr}, {29'h0, exp});
  endtask

  task automatic test_done;
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    test_done();
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    srst = 1'b1; cfg = '0; base = '0; mode = 2'b11; fn = 3'h0; preq = '0; creq = '0;
    serr_en = 1'b0; serr_c = 1'b0; perr_c = 1'b0; abt_c = 1'b0; fails = 0; compares = 0;
    rows = '{
      '{1'b0, 8'h30, 4'h0, 32'h0000_0000, 32'h0000_0000},
      '{1'b0, 8'h38, 4'h0, 32'h0000_0000, 32'h0000_0000},
      '{1'b0, 8'h3c, 4'h0, 32'h0000_0000, 32'h0340_01ff},
      '{1'b1, 8'h30, 4'hf, 32'hffff_ffff, 32'h0000_fffc},
      '{1'b1, 8'h38, 4'hf, 32'h1234_5677, 32'h0000_5674},
      '{1'b1, 8'h3c, 4'hf, 32'hffff_ff55, 32'h07ef_0155},
      '{1'b1, 8'h3c, 4'h3, 32'h0000_00aa, 32'h07ef_01aa},
      '{1'b1, 8'h3c, 4'hc, 32'h0000_0000, 32'h0000_01aa},
      '{1'b1, 8'h40, 4'hf, 32'hffff_ffff, 32'h0000_0000},
      '{1'b1, 8'h30, 4'hf, 32'h0000_0000, 32'h0000_0000},
      '{1'b1, 8'h38, 4'hf, 32'h0000_0000, 32'h0000_0000}
    };
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) cfg_wr(rows[i].addr, rows[i].be, rows[i].wdata);
      cfg_rd(rows[i].addr, rows[i].exp);
    end
    chk_bit(socket_reset_control, 1'b0);
    chk_word({26'h0, ctrl}, 32'h0000_0000);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      mode <= 2'(m);
      fn <= 3'h3;
      cfg_rd(8'h3c, {16'h0000, (m == 1) ? 8'h00 : 8'h04, 8'haa});
    end
    pci(32'h0000_0000, 1'b1, 1'b0);
    card_io(32'h0000_0000, 1'b1);
    @(posedge clk);
    base[0] <= 32'h0001_1000;
    cfg_wr(8'h30, 4'hf, 32'h0000_1ff0);
    pci(32'h0001_1ff3, 1'b1, 1'b1);
    pci(32'h0001_1ff4, 1'b1, 1'b0);
    pci(32'h0001_0ffc, 1'b1, 1'b0);
    pci(32'h0002_1ff0, 1'b1, 1'b0);
    card_io(32'h0001_1ff4, 1'b1);
    card_io(32'h0001_1000, 1'b0);
    @(posedge clk);
    base[0] <= 32'h0000_0000;
    cfg_wr(8'h30, 4'hf, 32'h0000_fffc);
    cfg_wr(8'h3c, 4'hc, 32'h078c_0000);
    #1;
    chk_word({26'h0, ctrl}, 32'h0000_003f);
    pci(32'h0000_0100, 1'b1, 1'b0);
    pci(32'h0000_04fc, 1'b1, 1'b1);
    pci(32'h0000_03c0, 1'b1, 1'b1);
    pci(32'h000a_0000, 1'b0, 1'b1);
    cfg_wr(8'h3c, 4'hc, 32'h0023_0000);
    pci(32'h0000_0100, 1'b1, 1'b1);
    pci(32'h000a_0000, 1'b0, 1'b0);
    @(posedge clk);
    serr_en <= 1'b1;
    card_ev(1'b1, 1'b1, 3'b111);
    @(posedge clk);
    serr_en <= 1'b0;
    card_ev(1'b1, 1'b0, 3'b100);
    cfg_wr(8'h3c, 4'hc, 32'h0002_0000);
    card_ev(1'b1, 1'b1, 3'b000);
    @(posedge clk);
    serr_c <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk_bit(pserr, 1'b0);
    @(posedge clk);
    #1;
    chk_bit(pserr, 1'b1);
    cfg_wr(8'h3c, 4'hc, 32'h0000_0000);
    repeat (2) @(posedge clk);
    #1;
    chk_bit(pserr, 1'b0);
    @(posedge clk);
    serr_c <= 1'b0;
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    chk_bit(socket_reset_control, 1'b1);
    cfg_rd(8'h3c, 32'h0340_04ff);
    test_done();
  end
endmodule
